// File: inc/wave_timer_pkg.sv
// Purpose: Shared constants and types for the waveform and one-shot timer.
// Assumes: Registers are eight bits wide and sit in the low bits of each word.
// Notes:   Offsets are word indices on the plain register port.
package wave_timer_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFS_PRESCALE    = 4'h0;
  localparam logic [3:0] OFS_SECONDARY   = 4'h1;
  localparam logic [3:0] OFS_PRIMARY     = 4'h2;
  localparam logic [3:0] OFS_OUTPUT_CTRL = 4'h3;
  localparam logic [3:0] OFS_MODE        = 4'h4;
  localparam logic [3:0] OFS_PULSE_MODE  = 4'h5;
  localparam logic [3:0] OFS_STATUS      = 4'h6;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int MODE_LO_BIT     = 0;  // Two bits of operating mode.
  localparam int SRC_LO_BIT      = 2;  // Two bits of count source select.
  localparam int RUN_BIT_POS     = 7;
  localparam int OS_START_POS    = 0;
  localparam int POLARITY_POS    = 1;
  localparam int OUT_SOURCE_POS  = 2;
  localparam int TRIG_ENABLE_POS = 0;
  localparam int TRIG_EDGE_POS   = 1;
  localparam int LATCH_BIT_POS   = 2;

  // ----------------------------------------------------------------------
  // Reset values and divider counts
  // ----------------------------------------------------------------------
  localparam logic [7:0] COUNT_RESET = 8'hff;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [2:0] DIV2_LAST   = 3'h1;
  localparam logic [2:0] DIV8_LAST   = 3'h7;

  typedef enum logic [1:0] {
    MODE_WAVE, MODE_ONESHOT, MODE_WAIT_ONESHOT, MODE_RESERVED
  } timer_mode_e;

  typedef enum logic [1:0] {
    SRC_F1, SRC_F2, SRC_F8, SRC_COMPANION
  } count_src_e;

  // Register port request.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage

// File: rtl/wave_timer.sv
// Purpose: Eight-bit down timer with prescaler producing waveform and one-shot pulses.
// Assumes: One 100 MHz clock, synchronous active-low reset, plain register port.
// Notes:   Half-cycle output and interrupt timing is approximated at the count-source tick.
`timescale 1ns/1ps

module wave_timer
  import wave_timer_pkg::*;
(
  // Clock and reset.
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  // Register port.
  input  wire logic [3:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // Companion timer underflow pulse, same clock.
  input  wire logic       companion_uflow_in,
  // External trigger pin and its interrupt input enable.
  input  wire logic       ext_trigger_pin_in,
  input  wire logic       ext_irq_input_enable_in,
  // Pulse output and events.
  output logic            pulse_out_pin_out,
  output logic            timer_irq_out,
  output logic            ext_irq_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pre_reload;   // Reload value seen by writes.
    logic [7:0] pri_reload;
    logic [7:0] sec_reload;
    logic [7:0] pre_active;   // Committed values used by the counter.
    logic [7:0] pri_active;
    logic [7:0] sec_active;
    logic [7:0] pre_cnt;
    logic [7:0] main_cnt;
    logic       in_secondary;
    logic       run;
    logic [1:0] mode;
    logic [1:0] src;
    logic       os_start;
    logic       polarity;
    logic       out_source;
    logic       out_source_used;
    logic       trig_enable;
    logic       trig_edge;
    logic       latch_bit;
    logic [2:0] div_cnt;
    logic       pin_meta;
    logic       pin_sync;
    logic       pin_prev;
    logic       wave_level;   // Logical level: 0 primary or idle, 1 secondary or pulse.
    logic       pulse_reg;
    logic       irq;
    logic       ext_irq;
    logic [7:0] rdata;
  } state_s;

  state_s   cur;
  state_s   nxt;
  reg_req_s req;

  assign req = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};

  // Outputs come straight from flops.
  assign reg_rdata_out     = cur.rdata;
  assign pulse_out_pin_out = cur.pulse_reg;
  assign timer_irq_out     = cur.irq;
  assign ext_irq_out       = cur.ext_irq;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic tick;
    logic pre_uf;
    logic main_uf;
    logic active_edge;
    logic busy;
    logic is_wave;
    logic is_os;
    logic stop_os;
    logic start_os;
    logic pri_wr;

    nxt         = cur;
    tick        = 1'b0;
    pre_uf      = 1'b0;
    main_uf     = 1'b0;
    stop_os     = 1'b0;
    start_os    = 1'b0;
    is_wave     = (timer_mode_e'(cur.mode) == MODE_WAVE);
    is_os       = (timer_mode_e'(cur.mode) == MODE_ONESHOT) || (timer_mode_e'(cur.mode) == MODE_WAIT_ONESHOT);
    busy        = cur.os_start;
    pri_wr      = req.wr && (req.addr == OFS_PRIMARY);
    nxt.irq     = 1'b0;
    nxt.ext_irq = 1'b0;

    // Count source divider and select.
    nxt.div_cnt = cur.div_cnt + 3'h1;
    case (count_src_e'(cur.src))
      SRC_F1:        tick = 1'b1;
      SRC_F2:        tick = (cur.div_cnt[0] == DIV2_LAST[0]);
      SRC_F8:        tick = (cur.div_cnt == DIV8_LAST);
      SRC_COMPANION: tick = companion_uflow_in;
      default:       tick = 1'b0;
    endcase

    // External pin synchroniser and edge detect.
    nxt.pin_meta = ext_trigger_pin_in;
    nxt.pin_sync = cur.pin_meta;
    nxt.pin_prev = cur.pin_sync;
    active_edge  = cur.trig_edge ? (!cur.pin_sync && cur.pin_prev) : (cur.pin_sync && !cur.pin_prev);
    nxt.ext_irq = active_edge && ext_irq_input_enable_in;

    // Register writes.
    if (req.wr) begin
      case (req.addr)
        OFS_PRESCALE: begin
          nxt.pre_reload = req.wdata;
          if (!cur.run) begin
            nxt.pre_active = req.wdata;
            nxt.pre_cnt    = req.wdata;
          end
        end
        OFS_SECONDARY: nxt.sec_reload = req.wdata;
        OFS_PRIMARY: begin
          // Writing the primary commits all reload values for the next primary period.
          nxt.pri_reload = req.wdata;
          nxt.pri_active = req.wdata;
          nxt.sec_active = cur.sec_reload;
          nxt.pre_active = cur.pre_reload;
          if (!cur.run) begin
            nxt.main_cnt = req.wdata;
            nxt.pre_cnt  = cur.pre_reload;
          end
        end
        OFS_OUTPUT_CTRL: begin
          nxt.os_start   = req.wdata[OS_START_POS];
          nxt.polarity   = req.wdata[POLARITY_POS];
          nxt.out_source = req.wdata[OUT_SOURCE_POS];
          if (req.wdata[OS_START_POS] && is_os && cur.run && !busy) begin
            start_os = 1'b1;
          end
          if (!req.wdata[OS_START_POS] && busy) begin
            stop_os = 1'b1;
          end
        end
        OFS_MODE: begin
          nxt.mode = req.wdata[MODE_LO_BIT +: 2];
          nxt.src  = req.wdata[SRC_LO_BIT +: 2];
          nxt.run  = req.wdata[RUN_BIT_POS];
          if (req.wdata[RUN_BIT_POS] && !cur.run) begin
            // Counting starts from the primary value.
            nxt.in_secondary    = 1'b0;
            nxt.wave_level      = 1'b0;
            nxt.main_cnt        = cur.pri_active;
            nxt.pre_cnt         = cur.pre_active;
            nxt.out_source_used = cur.out_source;
          end
          if (!req.wdata[RUN_BIT_POS] && busy) begin
            stop_os = 1'b1;
          end
        end
        OFS_PULSE_MODE: begin
          nxt.trig_enable = req.wdata[TRIG_ENABLE_POS];
          nxt.trig_edge   = req.wdata[TRIG_EDGE_POS];
          nxt.latch_bit   = req.wdata[LATCH_BIT_POS];
        end
        default: begin
        end
      endcase
    end

    // External trigger starts a one-shot only when idle.
    if (active_edge && cur.trig_enable && ext_irq_input_enable_in && is_os && cur.run && !busy) begin
      start_os = 1'b1;
    end

    // Counting: prescaler per tick, main counter per prescaler underflow.
    if (cur.run && (is_wave || busy) && tick && !pri_wr) begin
      if (cur.pre_cnt == 8'h00) begin
        pre_uf      = 1'b1;
        nxt.pre_cnt = cur.pre_active;
      end else begin
        nxt.pre_cnt = cur.pre_cnt - 8'h01;
      end
      if (pre_uf) begin
        if (cur.main_cnt == 8'h00) begin
          main_uf = 1'b1;
        end else begin
          nxt.main_cnt = cur.main_cnt - 8'h01;
        end
      end
    end

    // Underflow handling per mode.
    if (main_uf) begin
      if (is_wave) begin
        nxt.in_secondary = !cur.in_secondary;
        nxt.wave_level   = !cur.wave_level;
        nxt.main_cnt     = cur.in_secondary ? cur.pri_active : cur.sec_active;
        if (cur.in_secondary) begin
          nxt.irq             = 1'b1;
          nxt.out_source_used = cur.out_source;
        end
      end else if ((timer_mode_e'(cur.mode) == MODE_WAIT_ONESHOT) && !cur.in_secondary) begin
        nxt.in_secondary = 1'b1;
        nxt.wave_level   = 1'b1;
        nxt.main_cnt     = cur.sec_active;
      end else begin
        stop_os = 1'b1;
        nxt.irq = 1'b1;
      end
    end

    // One-shot start and stop; stop reloads before halting.
    if (start_os) begin
      nxt.os_start     = 1'b1;
      nxt.in_secondary = 1'b0;
      nxt.wave_level   = (timer_mode_e'(cur.mode) == MODE_ONESHOT);
      nxt.main_cnt     = cur.pri_active;
      nxt.pre_cnt      = cur.pre_active;
    end
    if (stop_os) begin
      nxt.os_start     = 1'b0;
      nxt.in_secondary = 1'b0;
      nxt.wave_level   = 1'b0;
      nxt.main_cnt     = cur.pri_active;
      nxt.pre_cnt      = cur.pre_active;
    end

    // Output level: latch bit or polarity-adjusted wave.
    // The next level is used so that the pin moves on the same edge as the timer event.
    if (is_wave && nxt.out_source_used) begin
      nxt.pulse_reg = cur.latch_bit;
    end else if (is_wave && cur.run) begin
      nxt.pulse_reg = nxt.wave_level ^ !cur.polarity;
    end else begin
      nxt.pulse_reg = nxt.wave_level ^ cur.polarity;
    end

    // Register reads return live prescaler and main counts; the secondary read returns its reload value.
    nxt.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        OFS_PRESCALE:    nxt.rdata = cur.pre_cnt;
        OFS_SECONDARY:   nxt.rdata = cur.sec_reload;
        OFS_PRIMARY:     nxt.rdata = cur.main_cnt;
        OFS_OUTPUT_CTRL: nxt.rdata = {5'h00, cur.out_source, cur.polarity, cur.os_start};
        OFS_MODE:        nxt.rdata = {cur.run, 3'h0, cur.src, cur.mode};
        OFS_PULSE_MODE:  nxt.rdata = {5'h00, cur.latch_bit, cur.trig_edge, cur.trig_enable};
        OFS_STATUS:      nxt.rdata = {6'h00, cur.wave_level, cur.in_secondary};
        default:         nxt.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cur            <= '0;
      cur.pre_reload <= COUNT_RESET;
      cur.pri_reload <= COUNT_RESET;
      cur.sec_reload <= COUNT_RESET;
      cur.pre_active <= COUNT_RESET;
      cur.pri_active <= COUNT_RESET;
      cur.sec_active <= COUNT_RESET;
      cur.pre_cnt    <= COUNT_RESET;
      cur.main_cnt   <= COUNT_RESET;
    end else begin
      cur <= nxt;
    end
  end

endmodule

// File: verification/far_side.sv
// Purpose: Trigger source and pulse load beside the timer.
// Assumes: The trigger pin idles high.
// Notes:   Widths are counted in clock cycles.
`timescale 1ns/1ps
module far_side (
  // Clock.
  input  wire logic clock_in,
  // Pins.
  output logic      trig_out,
  input  wire logic pulse_in
);
  // Trigger pin rests at its pull-up level.
  initial trig_out = 1'b1;
  // Low pulse of len cycles, giving a falling and a rising edge.
  task automatic fire(input int len);
    @(posedge clock_in);
    trig_out <= 1'b0;
    repeat (len) @(posedge clock_in);
    trig_out <= 1'b1;
  endtask
  // Cycles that the load sees away from the idle level.
  task automatic width(input logic idle, output int w);
    w = 0;
    for (int k = 0; k < 4000 && pulse_in === idle; k++) @(negedge clock_in);
    while (w < 4000 && pulse_in !== idle) begin
      @(negedge clock_in);
      w++;
    end
  endtask
endmodule

// File: verification/tb.sv
// Purpose: Self-checking bench for the waveform and one-shot timer.
// Assumes: Read data stand in the cycle after the read strobe.
// Notes:   Periods are measured in cycles between events.
`timescale 1ns/1ps
module tb
  import wave_timer_pkg::*;
;
  typedef struct {count_src_e src; logic [7:0] n, m, p; int div;} row_s;
  row_s rows [4] = '{'{SRC_F1, 8'h00, 8'h02, 8'h04, 1}, '{SRC_F2, 8'h01, 8'h01, 8'h00, 2},
                     '{SRC_F8, 8'h00, 8'h00, 8'h01, 8}, '{SRC_COMPANION, 8'h01, 8'h02, 8'h02, 3}};
  logic       clock_in, pulse, irq, ext_irq, trig;
  logic       rst_n_in = 1'b0, wr = 1'b0, rd = 1'b0, comp = 1'b0, ext_en = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [1:0] cnt3 = 2'h0;
  int         cyc = 0, n_ext = 0, n_errors = 0, comparisons = 0;
  wave_timer u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .companion_uflow_in(comp),
    .ext_trigger_pin_in(trig), .ext_irq_input_enable_in(ext_en), .pulse_out_pin_out(pulse),
    .timer_irq_out(irq), .ext_irq_out(ext_irq));
  far_side u_far (.clock_in(clock_in), .trig_out(trig), .pulse_in(pulse));
  // Clock at 100 MHz.
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // Cycle count, companion underflow every third cycle, tally of pin events.
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    cnt3 <= (cnt3 == 2'h2) ? 2'h0 : cnt3 + 2'h1;
    comp <= (cnt3 == 2'h2);
    if (ext_irq === 1'b1) n_ext <= n_ext + 1;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_irq(output int t);
    for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(negedge clock_in);
    t = cyc;
    @(negedge clock_in);
  endtask
  task automatic do_reset;
    rst_n_in <= 1'b0;
    repeat (8) @(posedge clock_in);
    rst_n_in <= 1'b1;
  endtask
  function automatic logic [7:0] md(logic run, count_src_e s, timer_mode_e m);
    return {run, 3'h0, s, m};
  endfunction
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog against a hang.
  initial begin
    repeat (40000) @(posedge clock_in);
    n_errors++;
    end_sim;
  end
  // Main sequence.
  initial begin
    int t0, t1, w, e0, per;
    logic [7:0] d;
    logic lvl;
    do_reset;
    foreach (rows[i]) begin
      wr_reg(OFS_MODE, 8'h00);
      wr_reg(OFS_PRESCALE, rows[i].n);
      wr_reg(OFS_SECONDARY, rows[i].p);
      wr_reg(OFS_PRIMARY, rows[i].m);
      wr_reg(OFS_MODE, md(1'b1, rows[i].src, MODE_WAVE));
      wait_irq(t0);
      per = rows[i].div * (rows[i].n + 1);
      lvl = pulse;
      for (int k = 0; k < 3000 && pulse === lvl; k++) @(negedge clock_in);
      check(cyc - t0, per * (rows[i].m + 1));
      wait_irq(t1);
      check(t1 - t0, per * (rows[i].m + rows[i].p + 2));
      $display("wave row %0d done", i);
    end
    do_reset;
    rd_reg(OFS_PRIMARY, d);
    check(d, COUNT_RESET);
    rd_reg(OFS_PRESCALE, d);
    check(d, COUNT_RESET);
    $display("reset test done");
    for (int pol = 0; pol < 2; pol++) begin
      wr_reg(OFS_OUTPUT_CTRL, {6'h0, pol[0], 1'b0});
      wr_reg(OFS_PRESCALE, 8'h01);
      wr_reg(OFS_PRIMARY, 8'h03);
      wr_reg(OFS_MODE, md(1'b1, SRC_F1, MODE_ONESHOT));
      repeat (2) @(negedge clock_in);
      lvl = pulse;
      check(lvl, pol[0]);
      fork
        u_far.width(lvl, w);
        wr_reg(OFS_OUTPUT_CTRL, {6'h0, pol[0], 1'b1});
      join
      check(w, 8);
      rd_reg(OFS_OUTPUT_CTRL, d);
      check(d[OS_START_POS], 1'b0);
    end
    ext_en <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      wr_reg(OFS_PULSE_MODE, {6'h0, e[0], 1'b1});
      e0 = n_ext;
      fork
        u_far.width(lvl, w);
        begin
          u_far.fire(2);
          u_far.fire(2);
        end
      join
      check(w, 8);
      check(n_ext - e0, 2);
    end
    $display("one-shot tests done");
    wr_reg(OFS_PRESCALE, 8'h00);
    wr_reg(OFS_SECONDARY, 8'h02);
    wr_reg(OFS_MODE, md(1'b1, SRC_F1, MODE_WAIT_ONESHOT));
    wr_reg(OFS_PRIMARY, 8'h03);
    fork
      u_far.width(lvl, w);
      wr_reg(OFS_OUTPUT_CTRL, 8'h03);
    join
    check(w, 3);
    rd_reg(OFS_PRIMARY, d);
    check(d, 8'h03);
    for (int s = 0; s < 2; s++) begin
      wr_reg(OFS_MODE, md(1'b1, SRC_F1, MODE_ONESHOT));
      wr_reg(OFS_PRIMARY, 8'hc8);
      wr_reg(OFS_OUTPUT_CTRL, 8'h03);
      repeat (10) @(negedge clock_in);
      if (s == 0) wr_reg(OFS_MODE, md(1'b0, SRC_F1, MODE_ONESHOT));
      else wr_reg(OFS_OUTPUT_CTRL, 8'h02);
      rd_reg(OFS_PRIMARY, d);
      check(d, 8'hc8);
      check(pulse, lvl);
    end
    $display("stop tests done");
    end_sim;
  end
endmodule

// File: verification/wave_timer_props.sv
// Purpose: Port timing checks for the timer.
// Assumes: Mode and control writes are seen on the register port.
// Notes:   Bound into every timer instance.
`timescale 1ns/1ps
module wave_timer_props
  import wave_timer_pkg::*;
(
  // Clock, reset and register writes.
  input wire logic       clock_in,
  input wire logic       rst_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  // Pins and events.
  input wire logic       ext_trigger_pin_in,
  input wire logic       ext_irq_input_enable_in,
  input wire logic       pulse_out_pin_out,
  input wire logic       timer_irq_out,
  input wire logic       ext_irq_out
);
  logic [7:0] mode_q;
  logic [7:0] octl_q;
  logic [2:0] age;
  logic       pin_q;
  logic       wave_on;
  logic       shot_on;
  // Shadows of mode and control writes, and the age of the last pin change.
  always_ff @(posedge clock_in) begin
    pin_q <= ext_trigger_pin_in;
    if (!rst_n_in) begin
      mode_q <= CTRL_RESET;
      octl_q <= CTRL_RESET;
      age    <= 3'h7;
    end else begin
      if (reg_wr_in && reg_addr_in == OFS_MODE) mode_q <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == OFS_OUTPUT_CTRL) octl_q <= reg_wdata_in;
      age <= (pin_q != ext_trigger_pin_in) ? 3'h0 : ((age == 3'h7) ? age : age + 3'h1);
    end
  end
  // Toggling output is in use in the waveform or a one-shot mode.
  assign wave_on = !octl_q[OUT_SOURCE_POS] && mode_q[1:0] == MODE_WAVE;
  assign shot_on = !octl_q[OUT_SOURCE_POS] && (mode_q[1] != mode_q[0]);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_reset_events_low: assert property ($rose(rst_n_in) |-> !timer_irq_out && !ext_irq_out)
    else $error("events not clear after reset");
  a_irq_one_cycle: assert property (timer_irq_out |=> !timer_irq_out)
    else $error("timer event longer than one cycle");
  a_ext_one_cycle: assert property (ext_irq_out |=> !ext_irq_out)
    else $error("pin event longer than one cycle");
  a_ext_needs_enable: assert property (!ext_irq_input_enable_in [*4] |-> !ext_irq_out)
    else $error("pin event while input disabled");
  a_ext_needs_edge: assert property (ext_irq_out |-> age < 3'h6)
    else $error("pin event without a pin edge");
  a_stopped_no_irq: assert property (!mode_q[RUN_BIT_POS] [*3] |-> !timer_irq_out)
    else $error("timer event while stopped");
  a_wave_irq_toggle: assert property (timer_irq_out && wave_on |-> $changed(pulse_out_pin_out))
    else $error("waveform event without output change");
  a_shot_irq_end: assert property (timer_irq_out && shot_on |-> $changed(pulse_out_pin_out))
    else $error("one-shot event without pulse end");
endmodule

bind wave_timer wave_timer_props u_props (.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .ext_trigger_pin_in(ext_trigger_pin_in),
  .ext_irq_input_enable_in(ext_irq_input_enable_in), .pulse_out_pin_out(pulse_out_pin_out),
  .timer_irq_out(timer_irq_out), .ext_irq_out(ext_irq_out));
